/* File: pin_mux_pkg.sv */
/*
 * Constants, register map and carrier types for the shared pin
 * multiplexer and general-purpose port block.
 * Assumes a 16-bit processor data bus with word addresses and one
 * 40 MHz system clock shared by bus, pins logic and peripherals.
 */
package pin_mux_pkg;

  localparam int NUM_PORTS = 6;
  localparam int NUM_PINS  = 48;

  // Word addresses in processor data space
  localparam logic [15:0] ADDR_SEL_A  = 16'h7090;
  localparam logic [15:0] ADDR_SEL_B  = 16'h7092;
  localparam logic [15:0] ADDR_SEL_C  = 16'h7094;
  localparam logic [15:0] ADDR_PORT_E = 16'h7095;
  localparam logic [15:0] ADDR_PORT_F = 16'h7096;
  localparam logic [15:0] ADDR_PORT_A = 16'h7098;
  localparam logic [15:0] ADDR_PORT_B = 16'h709a;
  localparam logic [15:0] ADDR_PORT_C = 16'h709c;
  localparam logic [15:0] ADDR_PORT_D = 16'h709e;

  // Port index inside the packed pin vectors (pin = port*8 + bit)
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;

  // Field positions within a port register
  localparam int DATA_LSB = 0;
  localparam int DIR_LSB  = 8;

  // Reset values of the mux control and port registers
  localparam logic [15:0] SEL_A_RESET = 16'h0000;
  localparam logic [15:0] SEL_B_RESET = 16'hfe03;
  localparam logic [15:0] SEL_C_RESET = 16'h0001;
  localparam logic [15:0] PORT_RESET  = 16'h0000;

  // Implemented bits; the rest read as zero
  localparam logic [15:0] SEL_C_MASK = 16'h3fff;
  localparam logic [NUM_PINS-1:0] PIN_MASK =
    {8'h3f, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff};

  // Pin index of the shared strobe / port C bit 0 pin
  localparam int STROBE_PIN = 16;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;

  // One processor data bus access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

  // Peripheral side of all pins
  typedef struct packed {
    logic [NUM_PINS-1:0] drive;
    logic [NUM_PINS-1:0] level;
  } periph_out_s;

endpackage : pin_mux_pkg

/* File: shared_pin_mux_gpio.sv */
/*
 * Shared pin multiplexer with six general-purpose ports A..F.
 * Assumes bus requests last one cycle and are synchronous to mclk,
 * pins are asynchronous and resolved by the surrounding pad ring.
 */
`timescale 1ns/1ps
module shared_pin_mux_gpio (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire pin_mux_pkg::bus_req_s         bus_req,
  output logic [15:0]                        bus_rdata,
  input  wire pin_mux_pkg::periph_out_s      periph_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0]   periph_in,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0]   pin_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0]   pin_oe_n
);
  import pin_mux_pkg::*;

  logic [NUM_PINS-1:0] sel_q, sel_d;
  logic [NUM_PINS-1:0] dat_q, dat_d;
  logic [NUM_PINS-1:0] dir_q, dir_d;
  logic [15:0]         rdata_q, rdata_d;
  logic [NUM_PINS-1:0] s1_q, s2_q, s3_q;
  logic [NUM_PINS-1:0] level_q, level_d;
  logic [NUM_PINS-1:0] out_q, out_d;
  logic [NUM_PINS-1:0] oe_n_q, oe_n_d;
  logic                sel_hit;
  logic [1:0]          sel_idx;
  logic                port_hit;
  logic [2:0]          port_idx;
  logic [7:0]          port_dat;
  logic [7:0]          port_dir;
  logic [7:0]          port_lvl;
  logic [7:0]          port_msk;
  logic [15:0]         sel_msk;

  // Input synchroniser: three stages, change taken when stages two and
  // three agree so that a single metastable sample never reaches logic
  always_comb begin : level_next
    level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge mclk) begin : level_regs
    if (!rst_n) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  // Address decode for the nine registers
  // data space map
  always_comb begin : decode
    sel_hit  = 1'b0;
    sel_idx  = 2'h0;
    port_hit = 1'b0;
    port_idx = PORT_A;
    case (bus_req.addr)
      ADDR_SEL_A: begin
        sel_hit = 1'b1;
        sel_idx = 2'h0;
      end
      ADDR_SEL_B: begin
        sel_hit = 1'b1;
        sel_idx = 2'h1;
      end
      ADDR_SEL_C: begin
        sel_hit = 1'b1;
        sel_idx = 2'h2;
      end
      ADDR_PORT_A: begin
        port_hit = 1'b1;
        port_idx = PORT_A;
      end
      ADDR_PORT_B: begin
        port_hit = 1'b1;
        port_idx = PORT_B;
      end
      ADDR_PORT_C: begin
        port_hit = 1'b1;
        port_idx = PORT_C;
      end
      ADDR_PORT_D: begin
        port_hit = 1'b1;
        port_idx = PORT_D;
      end
      ADDR_PORT_E: begin
        port_hit = 1'b1;
        port_idx = PORT_E;
      end
      ADDR_PORT_F: begin
        port_hit = 1'b1;
        port_idx = PORT_F;
      end
      default: begin
      end
    endcase
  end

  // Register writes and read data; unmapped reads return zero
  always_comb begin : reg_next
    sel_d    = sel_q;
    dat_d    = dat_q;
    dir_d    = dir_q;
    rdata_d  = rdata_q;
    port_dat = dat_q[port_idx*8 +: 8];
    port_dir = dir_q[port_idx*8 +: 8];
    port_lvl = level_q[port_idx*8 +: 8];
    port_msk = PIN_MASK[port_idx*8 +: 8];
    sel_msk  = (sel_idx == 2'h2) ? SEL_C_MASK : 16'hffff;
    if (bus_req.rd) begin
      rdata_d = 16'h0000;
    end
    if (sel_hit) begin
      if (bus_req.wr) begin
        sel_d[sel_idx*16 +: 16] = bus_req.wdata & sel_msk;
      end
      if (bus_req.rd) begin
        rdata_d = sel_q[sel_idx*16 +: 16];
      end
    end
    if (port_hit) begin
      // data low byte, direction high byte
      if (bus_req.wr) begin
        dat_d[port_idx*8 +: 8] = bus_req.wdata[DATA_LSB +: 8] & port_msk;
        dir_d[port_idx*8 +: 8] = bus_req.wdata[DIR_LSB +: 8] & port_msk;
      end
      // output reads latch, input reads pin
      if (bus_req.rd) begin
        rdata_d[DIR_LSB +: 8]  = port_dir;
        rdata_d[DATA_LSB +: 8] =
          ((port_dir & port_dat) | (~port_dir & port_lvl)) & port_msk;
      end
    end
  end

  // mux reset values put the strobe pin and clock out on function
  // strobe pin leaves reset in strobe mode
  always_ff @(posedge mclk) begin : reg_regs
    if (!rst_n) begin
      sel_q   <= {SEL_C_RESET, SEL_B_RESET, SEL_A_RESET};
      dat_q   <= {PORT_RESET[7:0], PORT_RESET[7:0], PORT_RESET[7:0],
                  PORT_RESET[7:0], PORT_RESET[7:0], PORT_RESET[7:0]};
      dir_q   <= {PORT_RESET[15:8], PORT_RESET[15:8], PORT_RESET[15:8],
                  PORT_RESET[15:8], PORT_RESET[15:8], PORT_RESET[15:8]};
      rdata_q <= 16'h0000;
    end else begin
      sel_q   <= sel_d;
      dat_q   <= dat_d;
      dir_q   <= dir_d;
      rdata_q <= rdata_d;
    end
  end

  // Per-pin routing between peripheral and port logic
  // every present pin with its mux bit set is driven by its own peripheral; absent D and F pins stay undriven
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    always_comb begin : route
      // mux bit 1 picks peripheral, 0 picks GPIO
      if (!PIN_MASK[i]) begin
        out_d[i]  = 1'b0;
        oe_n_d[i] = 1'b1;
      end else if (sel_q[i]) begin
        out_d[i]  = periph_out.level[i];
        oe_n_d[i] = ~periph_out.drive[i];
      end else begin
        // port bits only act in GPIO mode
        out_d[i]  = dat_q[i];
        oe_n_d[i] = ~dir_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin : pin_regs
    if (!rst_n) begin
      out_q  <= '0;
      oe_n_q <= '1;
    end else begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Outputs
  assign bus_rdata = rdata_q;
  assign pin_out   = out_q;
  assign pin_oe_n  = oe_n_q;
  assign periph_in = level_q;

  // Checks
  logic past_rst_n_q;
  always_ff @(posedge mclk) begin : past_reg
    past_rst_n_q <= rst_n;
  end

  sequence s_pin_held_high;
    pin_in[0] [*4];
  endsequence

  // Mux reset values visible right after reset
  a_reset_mux_values: assert property (@(posedge mclk)
    (rst_n && !past_rst_n_q) |->
      (sel_q[47:32] == SEL_C_RESET && sel_q[16] && !sel_q[0]))
    else $error("mux control reset value wrong");

  a_strobe_mode_reset: assert property (@(posedge mclk)
    (rst_n && !past_rst_n_q) |-> sel_q[STROBE_PIN])
    else $error("strobe pin not in strobe mode after reset");

  a_gpio_output_drive: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!sel_q[0] && dir_q[0]) ##1 (!sel_q[0] && dir_q[0]) |->
      (!pin_oe_n[0] && pin_out[0] == $past(dat_q[0])))
    else $error("gpio output pin not driven with its data bit");

  a_gpio_input_float: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!sel_q[8] && !dir_q[8]) |=> pin_oe_n[8])
    else $error("gpio input pin driven");

  a_periph_owns_pin: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (sel_q[32] && past_rst_n_q) |=>
      (pin_out[32] == $past(periph_out.level[32]) &&
       pin_oe_n[32] == !$past(periph_out.drive[32])))
    else $error("function pin not owned by its peripheral");

  a_port_layout: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == ADDR_PORT_E) |=>
      (dat_q[39:32] == $past(bus_req.wdata[7:0]) &&
       dir_q[39:32] == $past(bus_req.wdata[15:8])))
    else $error("port register layout wrong");

  a_input_readback: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ADDR_PORT_A && !dir_q[0]) |=>
      bus_rdata[0] == $past(level_q[0]))
    else $error("input pin read back wrong");

  a_mux_write_read: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == ADDR_SEL_A) ##1
      (bus_req.rd && bus_req.addr == ADDR_SEL_A) |=>
      bus_rdata == $past(bus_req.wdata, 2))
    else $error("mux control A not at its address");

  a_unmapped_zero: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == 16'h7091) |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_sync_settles: assert property (@(posedge mclk)
    disable iff (!rst_n)
    s_pin_held_high |=> level_q[0])
    else $error("pin level not taken within four cycles");

  sequence s_pin_held_low;
    (!pin_in[0]) [*4];
  endsequence

  a_sync_falls: assert property (@(posedge mclk)
    disable iff (!rst_n)
    s_pin_held_low |=> !level_q[0])
    else $error("pin low level not taken within four cycles");

  a_reset_pins_off: assert property (@(posedge mclk)
    (rst_n && !past_rst_n_q) |-> (pin_oe_n == {NUM_PINS{1'b1}}))
    else $error("pins driven right after reset");

  a_port_e_output: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!sel_q[33] && dir_q[33]) |=>
      (!pin_oe_n[33] && pin_out[33] == $past(dat_q[33])))
    else $error("port E pin one not driven with its data bit");

  a_strobe_gpio_drive: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (!sel_q[STROBE_PIN] && dir_q[STROBE_PIN]) |=>
      (!pin_oe_n[STROBE_PIN] &&
       pin_out[STROBE_PIN] == $past(dat_q[STROBE_PIN])))
    else $error("strobe pin not driven as gpio output");

  a_absent_pins_off: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (&pin_oe_n[31:25]) && (&pin_oe_n[47:46]))
    else $error("absent pin driven");

  a_sel_c_reserved: assert property (@(posedge mclk)
    disable iff (!rst_n)
    sel_q[47:46] == 2'b00)
    else $error("reserved mux C bits stored");

  a_sel_b_write: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.wr && bus_req.addr == ADDR_SEL_B) |=>
      sel_q[31:16] == $past(bus_req.wdata))
    else $error("mux control B write not stored");

  a_output_readback: assert property (@(posedge mclk)
    disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ADDR_PORT_A && dir_q[0]) |=>
      bus_rdata[0] == $past(dat_q[0]))
    else $error("output pin read back wrong");

  a_rdata_holds: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !bus_req.rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");

endmodule : shared_pin_mux_gpio

/* File: tb_top.sv */
/*
 * Self-checking testbench for the shared pin multiplexer and GPIO ports.
 * Assumes one 40 MHz clock, a synchronous active-low reset, and one-cycle
 * bus strobes. Inputs change at the falling edge only.
 */
`timescale 1ns/1ps
module tb_top;
  import pin_mux_pkg::*;

  logic                mclk;
  logic                rst_n;
  bus_req_s            bus_req;
  logic [15:0]         bus_rdata;
  periph_out_s         periph_out;
  logic [NUM_PINS-1:0] periph_in;
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe_n;
  int                  num_errors;
  int                  samples_checked;

  shared_pin_mux_gpio dut (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .bus_req   (bus_req),
    .bus_rdata (bus_rdata),
    .periph_out(periph_out),
    .periph_in (periph_in),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n)
  );

  // Clock at 25 ns period
  always #12.5 mclk = ~mclk;

  // Compare and count
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // One-cycle write strobe
  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    bus_req.wr    = 1'b1;
    bus_req.addr  = a;
    bus_req.wdata = d;
    @(negedge mclk);
    bus_req.wr = 1'b0;
  endtask : bus_wr

  // One-cycle read strobe, data registered at the sampling edge
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge mclk);
    bus_req.rd   = 1'b1;
    bus_req.addr = a;
    @(negedge mclk);
    bus_req.rd = 1'b0;
    d = bus_rdata;
  endtask : bus_rd

  // Reset values, map and an unmapped hole
  task automatic test_reset_map;
    logic [15:0] addrs [10] = '{ADDR_SEL_A, ADDR_SEL_B, ADDR_SEL_C,
      ADDR_PORT_E, ADDR_PORT_F, ADDR_PORT_A, ADDR_PORT_B, ADDR_PORT_C,
      ADDR_PORT_D, 16'h7097};
    logic [15:0] exps [10] = '{16'h0000, 16'hfe03, 16'h0001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] v;
    bus_wr(16'h7097, 16'hffff);
    for (int i = 0; i < 10; i++) begin
      bus_rd(addrs[i], v);
      check(v, exps[i]);
    end
    check(pin_oe_n, {NUM_PINS{1'b1}});
    $display("test reset_map done");
  endtask : test_reset_map

  // Output direction and data layout
  task automatic test_gpio_out;
    logic [15:0] v;
    bus_wr(ADDR_PORT_A, 16'h0101);
    bus_wr(ADDR_PORT_E, 16'h0202);
    idle(1);
    check(pin_out[0], 1'b1);
    check(pin_oe_n[0], 1'b0);
    check(pin_oe_n[33], 1'b0);
    check(pin_out[33], 1'b1);
    bus_rd(ADDR_PORT_A, v);
    check(v, 16'h0101);
    bus_wr(ADDR_PORT_A, 16'h0001);
    idle(1);
    check(pin_oe_n[0], 1'b1);
    $display("test gpio_out done");
  endtask : test_gpio_out

  // Input pin read back through the synchroniser
  task automatic test_gpio_in;
    logic [15:0] v;
    pin_in[0] = 1'b1;
    pin_in[1] = 1'b1;
    idle(5);
    check(periph_in[0], 1'b1);
    check(periph_in[1], 1'b1);
    bus_rd(ADDR_PORT_A, v);
    check(v, 16'h0003);
    $display("test gpio_in done");
  endtask : test_gpio_in

  // Peripheral routing per mux bit
  task automatic test_mux;
    periph_out.drive = {NUM_PINS{1'b1}};
    periph_out.level = {NUM_PINS{1'b1}};
    idle(2);
    check(pin_oe_n[16], 1'b0);
    check(pin_oe_n[32], 1'b0);
    check(pin_out[32], 1'b1);
    check(pin_oe_n[0], 1'b1);
    bus_wr(ADDR_SEL_A, 16'h0001);
    periph_out.level[0] = 1'b0;
    idle(2);
    check(pin_oe_n[0], 1'b0);
    check(pin_out[0], 1'b0);
    periph_out.drive = '0;
    idle(2);
    check(pin_oe_n[32], 1'b1);
    $display("test mux done");
  endtask : test_mux

  // Strobe pin handed to GPIO by clearing its mux bit
  task automatic test_strobe;
    logic [15:0] v;
    // bus high-impedance bit lives outside, never set
    bus_wr(ADDR_SEL_B, 16'hfe02);
    bus_wr(ADDR_PORT_C, 16'h0101);
    idle(1);
    check(pin_oe_n[16], 1'b0);
    check(pin_out[16], 1'b1);
    bus_rd(ADDR_SEL_B, v);
    check(v, 16'hfe02);
    $display("test strobe done");
  endtask : test_strobe

  // Write then read in the next cycle, reserved bits, unmapped hole
  task automatic test_back_to_back;
    logic [15:0] v;
    @(negedge mclk);
    bus_req.wr    = 1'b1;
    bus_req.addr  = ADDR_SEL_A;
    bus_req.wdata = 16'h8001;
    @(negedge mclk);
    bus_req.wr = 1'b0;
    bus_req.rd = 1'b1;
    @(negedge mclk);
    bus_req.rd = 1'b0;
    check(bus_rdata, 16'h8001);
    bus_wr(ADDR_SEL_C, 16'hc001);
    bus_rd(ADDR_SEL_C, v);
    check(v, 16'h0001);
    bus_rd(16'h7091, v);
    check(v, 16'h0000);
    $display("test back_to_back done");
  endtask : test_back_to_back

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    mclk             = 1'b0;
    rst_n            = 1'b0;
    bus_req          = '0;
    periph_out       = '0;
    pin_in           = '0;
    num_errors       = 0;
    samples_checked  = 0;
    idle(16);
    rst_n = 1'b1;
    test_reset_map();
    test_gpio_out();
    test_gpio_in();
    test_mux();
    test_strobe();
    test_back_to_back();
    print_verdict();
  end

  // Watchdog well past the expected run
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
